//--- core/pds_defs.vh
// Purpose: constants of the preamble detector and byte synchroniser
// Assumes: 32-bit AXI4-Lite, one aligned word per register
// Notes: register indices are kept, byte address is four times the index
`ifndef PDS_DEFS_VH
`define PDS_DEFS_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define PDS_IDX_CTRL 8'hD3
`define PDS_IDX_SYNC 8'hD4
`define PDS_IDX_MODE 8'hD5
`define PDS_IDX_STAT 8'hD6
`define PDS_ADDR_W 12
`define PDS_ADDR_CTRL 12'h34C
`define PDS_ADDR_SYNC 12'h350
`define PDS_ADDR_MODE 12'h354
`define PDS_ADDR_STAT 12'h358

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define PDS_CTRL_EN_BIT 7
`define PDS_CTRL_LEN_MSB 6
`define PDS_CTRL_RST 8'h00
`define PDS_SYNC_RST 8'h00
`define PDS_MODE_BYTE_BIT 0
`define PDS_MODE_RST 1'b0

// ----------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------
`define PDS_CNT_MAX 7'h7F
`define PDS_WAIT_BITS 3'h7
`define PDS_BYTE_BITS 3'h7

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define PDS_RESP_OKAY 2'h0
`define PDS_RESP_SLVERR 2'h2

`endif

//--- core/pds_shift.v
// Purpose: eight-bit receive window and saturating alternating-bit counter
// Assumes: one bit strobe per bit period, same clock as the caller
// Notes: clr empties the counter but keeps the window
`timescale 1ns/1ns
`include "pds_defs.vh"

module pds_shift (
    // Clock and control
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire clr_i,
    // Bit stream
    input wire bit_stb_i,
    input wire bit_i,
    // Results
    output reg [7:0] window_o,
    output reg [6:0] alt_cnt_o
);

    reg prev_r;
    reg have_prev_r;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            window_o <= 8'h00;
            alt_cnt_o <= 7'h00;
            prev_r <= 1'b0;
            have_prev_r <= 1'b0;
        end else if (ce_i) begin
            if (clr_i) begin
                alt_cnt_o <= 7'h00;
                have_prev_r <= 1'b0;
            end else if (bit_stb_i) begin
                // Equal neighbours clear, differing ones count, saturating
                if (have_prev_r && (bit_i != prev_r)) begin
                    if (alt_cnt_o != `PDS_CNT_MAX)
                        alt_cnt_o <= alt_cnt_o + 7'h01;
                end else begin
                    alt_cnt_o <= 7'h00;
                end
                have_prev_r <= 1'b1;
            end
            if (bit_stb_i) begin
                window_o <= {window_o[6:0], bit_i};
                prev_r <= bit_i;
            end
        end
    end

endmodule // pds_shift

//--- core/pds_top.v
// Purpose: preamble detector and byte synchroniser of the receive path
// Assumes: demodulated bits arrive with a one-cycle strobe on CLK_I
// Notes: registers over AXI4-Lite; received bytes leave as one-cycle pulses
`timescale 1ns/1ns
`include "pds_defs.vh"

module pds_top (
    // Clock, reset, enable
    input wire CLK_I,
    input wire RST_N_I,
    input wire CE_I,
    // AXI4-Lite write address
    input wire AWVALID_I,
    output wire AWREADY_O,
    input wire [`PDS_ADDR_W-1:0] AWADDR_I,
    input wire [2:0] AWPROT_I,
    // AXI4-Lite write data
    input wire WVALID_I,
    output wire WREADY_O,
    input wire [31:0] WDATA_I,
    input wire [3:0] WSTRB_I,
    // AXI4-Lite write response
    output reg BVALID_O,
    input wire BREADY_I,
    output reg [1:0] BRESP_O,
    // AXI4-Lite read address
    input wire ARVALID_I,
    output wire ARREADY_O,
    input wire [`PDS_ADDR_W-1:0] ARADDR_I,
    input wire [2:0] ARPROT_I,
    // AXI4-Lite read data
    output reg RVALID_O,
    input wire RREADY_I,
    output reg [31:0] RDATA_O,
    output reg [1:0] RRESP_O,
    // Demodulated bit stream
    input wire RX_BIT_STB_I,
    input wire RX_BIT_I,
    // Receive buffer, interrupt request and sync-found status
    output reg RX_DATA_VALID_O,
    output reg [7:0] RX_DATA_O,
    output reg RF_IRQ_O,
    output reg SYNC_FOUND_O
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam ST_OFF = 3'h0;
    localparam ST_PRE = 3'h1;
    localparam ST_SRCH = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_RECV = 3'h4;

    reg [7:0] preamble_detect_control;
    reg [7:0] sync_byte_pattern_reg;
    reg byte_mode_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [2:0] wait_cnt_r;
    reg [2:0] wait_cnt_nxt;
    reg [2:0] bit_cnt_r;
    reg [2:0] bit_cnt_nxt;
    reg [7:0] asm_r;
    reg [7:0] asm_nxt;
    reg out_valid_nxt;
    reg [7:0] out_data_nxt;
    reg irq_nxt;
    reg cnt_clr;

    wire sync_en = preamble_detect_control[`PDS_CTRL_EN_BIT];
    wire [6:0] preamble_length_threshold = preamble_detect_control[`PDS_CTRL_LEN_MSB:0];
    wire [7:0] window;
    wire [6:0] alt_cnt;
    wire [7:0] win_next = {window[6:0], RX_BIT_I};
    wire sync_hit = (win_next == sync_byte_pattern_reg);
    // Break of the 0-1 pattern: new bit equals the previous one
    wire pattern_break = (RX_BIT_I == window[0]);

    // ------------------------------------------------------------------
    // Window and alternating counter
    // ------------------------------------------------------------------
    pds_shift u_shift (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .clr_i(cnt_clr),
        .bit_stb_i(RX_BIT_STB_I),
        .bit_i(RX_BIT_I),
        .window_o(window),
        .alt_cnt_o(alt_cnt)
    );

    // ------------------------------------------------------------------
    // Detection and framing
    // ------------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        wait_cnt_nxt = wait_cnt_r;
        bit_cnt_nxt = bit_cnt_r;
        asm_nxt = asm_r;
        out_valid_nxt = 1'b0;
        out_data_nxt = RX_DATA_O;
        irq_nxt = 1'b0;
        cnt_clr = 1'b0;
        if (!sync_en) begin
            state_nxt = ST_OFF;
            cnt_clr = 1'b1;
            wait_cnt_nxt = 3'h0;
            if (RX_BIT_STB_I) begin
                if (byte_mode_r) begin
                    // Whole bytes, first bit ends up as MSB
                    asm_nxt = {asm_r[6:0], RX_BIT_I};
                    bit_cnt_nxt = bit_cnt_r + 3'h1;
                    if (bit_cnt_r == `PDS_BYTE_BITS) begin
                        out_valid_nxt = 1'b1;
                        out_data_nxt = {asm_r[6:0], RX_BIT_I};
                    end
                end else begin
                    out_valid_nxt = 1'b1;
                    out_data_nxt = {7'h00, RX_BIT_I};
                    bit_cnt_nxt = 3'h0;
                end
            end
        end else begin
            case (state_r)
                ST_OFF: begin
                    // Session starts on the enable edge; select bit now ignored
                    state_nxt = ST_PRE;
                    cnt_clr = 1'b1;
                end
                ST_PRE: begin
                    // Threshold of 0 is illegal; it would search at once
                    if (alt_cnt >= preamble_length_threshold)
                        state_nxt = ST_SRCH;
                end
                ST_SRCH: begin
                    if (RX_BIT_STB_I && sync_hit) begin
                        state_nxt = ST_RECV;
                        out_valid_nxt = 1'b1;
                        out_data_nxt = win_next;
                        irq_nxt = 1'b1;
                        bit_cnt_nxt = 3'h0;
                    end else if (RX_BIT_STB_I && pattern_break) begin
                        state_nxt = ST_WAIT;
                        wait_cnt_nxt = 3'h0;
                    end
                end
                ST_WAIT: begin
                    if (RX_BIT_STB_I) begin
                        if (sync_hit) begin
                            state_nxt = ST_RECV;
                            out_valid_nxt = 1'b1;
                            out_data_nxt = win_next;
                            irq_nxt = 1'b1;
                            bit_cnt_nxt = 3'h0;
                        end else if (wait_cnt_r == `PDS_WAIT_BITS - 3'h1) begin
                            state_nxt = ST_PRE;
                            cnt_clr = 1'b1;
                        end else begin
                            wait_cnt_nxt = wait_cnt_r + 3'h1;
                        end
                    end
                end
                ST_RECV: begin
                    // Enable left set has no further effect here
                    if (RX_BIT_STB_I) begin
                        asm_nxt = {asm_r[6:0], RX_BIT_I};
                        bit_cnt_nxt = bit_cnt_r + 3'h1;
                        if (bit_cnt_r == `PDS_BYTE_BITS) begin
                            out_valid_nxt = 1'b1;
                            out_data_nxt = {asm_r[6:0], RX_BIT_I};
                        end
                    end
                end
                default: begin
                    state_nxt = ST_OFF;
                end
            endcase
        end
    end

    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state_r <= ST_OFF;
            wait_cnt_r <= 3'h0;
            bit_cnt_r <= 3'h0;
            asm_r <= 8'h00;
            RX_DATA_VALID_O <= 1'b0;
            RX_DATA_O <= 8'h00;
            RF_IRQ_O <= 1'b0;
            SYNC_FOUND_O <= 1'b0;
        end else if (CE_I) begin
            state_r <= state_nxt;
            wait_cnt_r <= wait_cnt_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            asm_r <= asm_nxt;
            RX_DATA_VALID_O <= out_valid_nxt;
            RX_DATA_O <= out_data_nxt;
            RF_IRQ_O <= irq_nxt;
            SYNC_FOUND_O <= (state_nxt == ST_RECV);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    reg aw_full_r;
    reg w_full_r;
    reg [`PDS_ADDR_W-1:0] aw_addr_r;
    reg [7:0] w_data_r;
    reg w_lane_r;
    reg [7:0] rd_val;
    reg rd_hit;

    // A frozen slave must not signal acceptance, or the item would be lost
    assign AWREADY_O = CE_I && !aw_full_r && !BVALID_O;
    assign WREADY_O = CE_I && !w_full_r && !BVALID_O;
    assign ARREADY_O = CE_I && !RVALID_O;

    wire wr_go = aw_full_r && w_full_r && !BVALID_O;
    wire wr_ctrl = (aw_addr_r[`PDS_ADDR_W-1:2] == {2'h0, `PDS_IDX_CTRL});
    wire wr_sync = (aw_addr_r[`PDS_ADDR_W-1:2] == {2'h0, `PDS_IDX_SYNC});
    wire wr_mode = (aw_addr_r[`PDS_ADDR_W-1:2] == {2'h0, `PDS_IDX_MODE});
    wire wr_stat = (aw_addr_r[`PDS_ADDR_W-1:2] == {2'h0, `PDS_IDX_STAT});

    always @* begin
        rd_hit = 1'b1;
        case (ARADDR_I[`PDS_ADDR_W-1:2])
            {2'h0, `PDS_IDX_CTRL}: rd_val = preamble_detect_control;
            {2'h0, `PDS_IDX_SYNC}: rd_val = sync_byte_pattern_reg;
            {2'h0, `PDS_IDX_MODE}: rd_val = {7'h00, byte_mode_r};
            {2'h0, `PDS_IDX_STAT}: rd_val = {1'b0, SYNC_FOUND_O, 3'h0, state_r};
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= {`PDS_ADDR_W{1'b0}};
            w_data_r <= 8'h00;
            w_lane_r <= 1'b0;
            BVALID_O <= 1'b0;
            BRESP_O <= `PDS_RESP_OKAY;
            RVALID_O <= 1'b0;
            RDATA_O <= 32'h00000000;
            RRESP_O <= `PDS_RESP_OKAY;
            preamble_detect_control <= `PDS_CTRL_RST;
            sync_byte_pattern_reg <= `PDS_SYNC_RST;
            byte_mode_r <= `PDS_MODE_RST;
        end else if (CE_I) begin
            if (AWVALID_I && AWREADY_O) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= AWADDR_I;
            end
            if (WVALID_I && WREADY_O) begin
                w_full_r <= 1'b1;
                w_data_r <= WDATA_I[7:0];
                w_lane_r <= WSTRB_I[0];
            end
            if (wr_go) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                BVALID_O <= 1'b1;
                BRESP_O <= (wr_ctrl || wr_sync || wr_mode || wr_stat) ?
                    `PDS_RESP_OKAY : `PDS_RESP_SLVERR;
                if (w_lane_r && wr_ctrl)
                    preamble_detect_control <= w_data_r;
                if (w_lane_r && wr_sync)
                    sync_byte_pattern_reg <= w_data_r;
                if (w_lane_r && wr_mode)
                    byte_mode_r <= w_data_r[`PDS_MODE_BYTE_BIT];
            end else if (BVALID_O && BREADY_I) begin
                BVALID_O <= 1'b0;
            end
            if (ARVALID_I && ARREADY_O) begin
                RVALID_O <= 1'b1;
                RDATA_O <= {24'h000000, rd_val};
                RRESP_O <= rd_hit ? `PDS_RESP_OKAY : `PDS_RESP_SLVERR;
            end else if (RVALID_O && RREADY_I) begin
                RVALID_O <= 1'b0;
            end
        end
    end

endmodule // pds_top

//--- test/pds_top_chk.sv
// Purpose: port checks of the preamble detector and byte synchroniser
// Assumes: writes offer address and data together
// Notes: enable, pattern and bit window are mirrored from the ports
`timescale 1ns/1ns
`include "pds_defs.vh"
module pds_top_chk (
    // Bus
    input wire CLK_I,
    input wire RST_N_I,
    input wire CE_I,
    input wire AWVALID_I,
    input wire AWREADY_O,
    input wire [`PDS_ADDR_W-1:0] AWADDR_I,
    input wire WVALID_I,
    input wire WREADY_O,
    input wire [31:0] WDATA_I,
    input wire BVALID_O,
    input wire BREADY_I,
    input wire [1:0] BRESP_O,
    input wire RVALID_O,
    input wire RREADY_I,
    input wire [31:0] RDATA_O,
    // Receive path
    input wire RX_BIT_STB_I,
    input wire RX_BIT_I,
    input wire RX_DATA_VALID_O,
    input wire [7:0] RX_DATA_O,
    input wire RF_IRQ_O,
    input wire SYNC_FOUND_O
);
    reg en_r;
    reg [7:0] sync_r;
    reg [7:0] win_r;
    wire wr_take = AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
    wire bad_aw = AWADDR_I != `PDS_ADDR_CTRL && AWADDR_I != `PDS_ADDR_SYNC
        && AWADDR_I != `PDS_ADDR_MODE && AWADDR_I != `PDS_ADDR_STAT;
    // Split address and data writes are not mirrored
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            en_r <= 1'b0;
            sync_r <= 8'h00;
            win_r <= 8'h00;
        end else begin
            if (wr_take && AWADDR_I == `PDS_ADDR_CTRL)
                en_r <= WDATA_I[7];
            if (wr_take && AWADDR_I == `PDS_ADDR_SYNC)
                sync_r <= WDATA_I[7:0];
            if (CE_I && RX_BIT_STB_I)
                win_r <= {win_r[6:0], RX_BIT_I};
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    // Frozen cycles shift every timing, so checks pause with the enable
    default disable iff (!RST_N_I || !CE_I);
    sequence s_irq;
        RF_IRQ_O && RX_DATA_VALID_O;
    endsequence
    sequence s_quiet;
        !RF_IRQ_O [*8];
    endsequence
    property p_wr_resp;
        wr_take |-> ##2 (BVALID_O
            && BRESP_O == ($past(bad_aw, 2) ? `PDS_RESP_SLVERR : `PDS_RESP_OKAY));
    endproperty
    property p_b_hold;
        BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O);
    endproperty
    property p_r_hold;
        RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O);
    endproperty
    property p_irq_en;
        RF_IRQ_O |-> en_r;
    endproperty
    property p_irq_data;
        RF_IRQ_O |-> s_irq ##0 (RX_DATA_O == sync_r && win_r == sync_r);
    endproperty
    property p_irq_pulse;
        s_irq |=> s_quiet;
    endproperty
    property p_found;
        $rose(SYNC_FOUND_O) |-> RF_IRQ_O || $past(RF_IRQ_O);
    endproperty
    property p_found_hold;
        SYNC_FOUND_O && en_r |=> SYNC_FOUND_O;
    endproperty
    property p_data_hold;
        $changed(RX_DATA_O) |-> RX_DATA_VALID_O;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response wrong");
    a_b_hold: assert property (p_b_hold)
        else $error("write response not held");
    a_r_hold: assert property (p_r_hold)
        else $error("read data not held");
    a_irq_en: assert property (p_irq_en)
        else $error("interrupt while disabled");
    a_irq_data: assert property (p_irq_data)
        else $error("interrupt without matching byte");
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt repeated");
    a_found: assert property (p_found)
        else $error("found without interrupt");
    a_found_hold: assert property (p_found_hold)
        else $error("found dropped while enabled");
    a_data_hold: assert property (p_data_hold)
        else $error("buffer changed without valid");
endmodule // pds_top_chk

bind pds_top pds_top_chk chk_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
    .AWVALID_I(AWVALID_I),
    .AWREADY_O(AWREADY_O), .AWADDR_I(AWADDR_I), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
    .WDATA_I(WDATA_I), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .BRESP_O(BRESP_O),
    .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .RDATA_O(RDATA_O),
    .RX_BIT_STB_I(RX_BIT_STB_I), .RX_BIT_I(RX_BIT_I), .RX_DATA_VALID_O(RX_DATA_VALID_O),
    .RX_DATA_O(RX_DATA_O), .RF_IRQ_O(RF_IRQ_O), .SYNC_FOUND_O(SYNC_FOUND_O));

//--- test/pds_tx_model.sv
// Purpose: remote transmitter on the demodulated bit stream
// Assumes: one strobe per bit, gap idle clocks after it
// Notes: gap is raised by the bench for a slow sender
`timescale 1ns/1ns
module pds_tx_model (
    // Clock
    input wire clk_i,
    // Bit stream
    output reg stb_o,
    output reg bit_o
);
    integer gap = 2;
    integer k;
    initial begin
        stb_o = 1'b0;
        bit_o = 1'b0;
    end
    task send_bit(input b);
        begin
            @(posedge clk_i);
            stb_o <= 1'b1;
            bit_o <= b;
            @(posedge clk_i);
            stb_o <= 1'b0;
            // Released line shows the opposite, never a held value
            bit_o <= ~b;
            repeat (gap) @(posedge clk_i);
        end
    endtask
    task send_pre(input integer n);
        for (k = n - 1; k >= 0; k = k - 1)
            send_bit(k[0]);
    endtask
    task send_byte(input [7:0] b);
        for (k = 7; k >= 0; k = k - 1)
            send_bit(b[k]);
    endtask
endmodule // pds_tx_model

//--- test/pds_top_test.sv
// Purpose: self-checking bench of the preamble detector and byte synchroniser
// Assumes: transmitter model spaces its bits by a few clocks
// Notes: protection and strobe inputs are tied
`timescale 1ns/1ns
`include "pds_defs.vh"
`define CHK(nm, ex, got) begin n_compared = n_compared + 1; if ((got) !== (ex)) begin \
    err_total = err_total + 1; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module pds_top_test;
    reg clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
    reg rready = 1'b0, ce = 1'b1, ta, tw;
    reg [11:0] awa = 12'h000, ara = 12'h000;
    reg [31:0] wd = 32'h00000000, rdat;
    reg [1:0] resp;
    reg [7:0] irq_d = 8'h00, last_d = 8'h00;
    integer err_total = 0, n_compared = 0, irq_n = 0, n0, i;
    wire awr, wr, bv, arr, rv, rdv, irq, fnd, stb, bt;
    wire [1:0] br, rr;
    wire [31:0] rd;
    wire [7:0] rxd;
    pds_tx_model tx_u (.clk_i(clk), .stb_o(stb), .bit_o(bt));
    pds_top dut_u (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .AWVALID_I(awv),
        .AWREADY_O(awr), .AWADDR_I(awa), .AWPROT_I(3'h0), .WVALID_I(wv), .WREADY_O(wr),
        .WDATA_I(wd), .WSTRB_I(4'hF), .BVALID_O(bv), .BREADY_I(bready), .BRESP_O(br),
        .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara), .ARPROT_I(3'h0), .RVALID_O(rv),
        .RREADY_I(rready), .RDATA_O(rd), .RRESP_O(rr), .RX_BIT_STB_I(stb), .RX_BIT_I(bt),
        .RX_DATA_VALID_O(rdv), .RX_DATA_O(rxd), .RF_IRQ_O(irq), .SYNC_FOUND_O(fnd));
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        if (irq) begin
            irq_n = irq_n + 1;
            irq_d = rxd;
        end
        if (rdv)
            last_d = rxd;
    end
    // ------------------------------------------------------------
    // Bus tasks: readiness sampled at the falling edge, acted on at the rising
    // ------------------------------------------------------------
    task axi_wr(input [11:0] a, input [7:0] d);
        begin
            ta = 1'b0;
            tw = 1'b0;
            @(posedge clk);
            awv <= 1'b1;
            awa <= a;
            wv <= 1'b1;
            wd <= {24'h000000, d};
            do begin
                @(negedge clk);
                ta = ta | (awv & awr);
                tw = tw | (wv & wr);
                @(posedge clk);
                if (ta)
                    awv <= 1'b0;
                if (tw)
                    wv <= 1'b0;
            end while (!(ta && tw));
            do @(negedge clk); while (!bv);
            @(posedge clk);
            bready <= 1'b1;
            @(negedge clk);
            resp = br;
            @(posedge clk);
            bready <= 1'b0;
        end
    endtask
    task axi_rd(input [11:0] a);
        begin
            @(posedge clk);
            arv <= 1'b1;
            ara <= a;
            do begin
                @(negedge clk);
                ta = arr;
                @(posedge clk);
            end while (!ta);
            arv <= 1'b0;
            do @(negedge clk); while (!rv);
            @(posedge clk);
            rready <= 1'b1;
            @(negedge clk);
            rdat = rd;
            resp = rr;
            @(posedge clk);
            rready <= 1'b0;
        end
    endtask
    // Balanced pattern with two equal pairs, distinct from the preamble
    task detect(input [6:0] thr, input integer pre, input [7:0] dat, input integer n_irq);
        begin
            axi_wr(`PDS_ADDR_CTRL, 8'h00);
            axi_wr(`PDS_ADDR_SYNC, 8'hCA);
            axi_wr(`PDS_ADDR_CTRL, {1'b1, thr});
            n0 = irq_n;
            tx_u.send_pre(pre);
            // No filter in the model; a manual lock would follow this byte
            tx_u.send_byte(8'hCA);
            @(negedge clk);
            `CHK("irq count", n_irq, irq_n - n0)
            if (n_irq == 1) begin
                `CHK("sync byte", 8'hCA, irq_d)
                `CHK("found", 1'b1, fnd)
                axi_rd(`PDS_ADDR_STAT);
                `CHK("status", 32'h00000044, rdat)
                tx_u.send_byte(dat);
                @(negedge clk);
                `CHK("data byte", dat, last_d)
            end
        end
    endtask
    task t_regs;
        begin
            axi_rd(`PDS_ADDR_SYNC);
            `CHK("sync reset", 32'h00000000, rdat)
            axi_wr(`PDS_ADDR_CTRL, 8'h05);
            axi_rd(`PDS_ADDR_CTRL);
            `CHK("ctrl rw", 32'h00000005, rdat)
            axi_wr(12'h360, 8'hFF);
            `CHK("unmapped wr", `PDS_RESP_SLVERR, resp)
            axi_rd(12'h360);
            `CHK("unmapped rd", `PDS_RESP_SLVERR, resp)
        end
    endtask
    task t_off;
        begin
            axi_wr(`PDS_ADDR_SYNC, 8'hCA);
            n0 = irq_n;
            tx_u.send_pre(12);
            tx_u.send_byte(8'hCA);
            tx_u.send_bit(1'b1);
            @(negedge clk);
            `CHK("bit mode", 8'h01, last_d)
            `CHK("irq off", 0, irq_n - n0)
            // A bit offered while frozen must leave no trace
            @(posedge clk);
            ce <= 1'b0;
            tx_u.send_bit(1'b0);
            ce <= 1'b1;
            @(negedge clk);
            `CHK("frozen bit", 8'h01, last_d)
            tx_u.send_bit(1'b0);
            @(negedge clk);
            `CHK("bit after freeze", 8'h00, last_d)
        end
    endtask
    task t_lengths;
        begin
            detect(7'd8, 8, 8'h5B, 1);
            detect(7'd8, 7, 8'h00, 0);
            detect(7'd1, 2, 8'h3C, 1);
            tx_u.gap = 5;
            axi_wr(`PDS_ADDR_MODE, 8'h01);
            axi_rd(`PDS_ADDR_MODE);
            `CHK("mode rw", 32'h00000001, rdat)
            detect(7'h7F, 135, 8'hE1, 1);
            tx_u.gap = 2;
        end
    endtask
    task t_timeout;
        begin
            detect(7'd8, 0, 8'h00, 0);
            n0 = irq_n;
            tx_u.send_pre(10);
            for (i = 0; i < 9; i = i + 1)
                tx_u.send_bit(1'b1);
            tx_u.send_byte(8'hCA);
            tx_u.send_pre(10);
            // Break bit, then the byte: its match would come one bit too late
            tx_u.send_bit(1'b0);
            tx_u.send_byte(8'hCA);
            tx_u.send_pre(10);
            axi_wr(`PDS_ADDR_CTRL, 8'h00);
            axi_wr(`PDS_ADDR_CTRL, 8'h88);
            tx_u.send_byte(8'hCA);
            @(negedge clk);
            `CHK("late or restarted", 0, irq_n - n0)
            // Byte opens on the breaking bit: match on the seventh bit after it
            tx_u.send_pre(10);
            tx_u.send_bit(1'b1);
            tx_u.send_byte(8'hCA);
            @(negedge clk);
            `CHK("last bit in time", 1, irq_n - n0)
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_off;
        t_lengths;
        t_timeout;
        results;
    end
    initial begin
        #3000000;
        err_total = err_total + 1;
        results;
    end
endmodule // pds_top_test
